// ==== rtl/pec_checker.sv ====
// Receive packet error checker with per-port buffers and register slave
`timescale 1ns/1ps
module pec_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   // Incoming packet words
   input wire logic in_valid_i,
   input wire logic [pec_pkg::AW-1:0] in_addr_i,
   input wire logic in_sop_i,
   input wire logic in_eop_i,
   input wire logic [pec_pkg::DW-1:0] in_data_i,
   // User read side, one lane per port
   input wire logic [pec_pkg::NP-1:0] rd_en_i,
   output logic [pec_pkg::NP-1:0] rd_valid_o,
   output logic [pec_pkg::NP-1:0][pec_pkg::DW-1:0] rd_data_o,
   output logic [pec_pkg::NP-1:0] rd_sop_o,
   output logic [pec_pkg::NP-1:0] user_read_end_out_o,
   output logic [pec_pkg::NP-1:0] user_read_error_out_o,
   output logic [pec_pkg::NP-1:0] data_avail_o,
   // Status flags
   output logic [pec_pkg::NP-1:0] fifo_empty_status_o,
   output logic [pec_pkg::NP-1:0] fifo_overflow_flag_o,
   output logic [pec_pkg::NP-1:0] missing_start_flag_o,
   output logic [pec_pkg::NP-1:0] missing_end_flag_o,
   output logic [pec_pkg::AW-1:0] failing_packet_port_addr_o
);
   typedef struct packed {
      pec_pkg::pec_mode_type [pec_pkg::NP-1:0] mode;
      logic [pec_pkg::NP-1:0] ovf;
      logic [pec_pkg::NP-1:0] ms;
      logic [pec_pkg::NP-1:0] me;
      logic [pec_pkg::AW-1:0] fail_addr;
      logic [1:0] ctrl;
      logic ack;
      logic [31:0] dat;
   } pec_top_state_type;

   pec_top_state_type r, n;
   logic [pec_pkg::NP-1:0] we_c, wsop_c, weop_c, werr_c;
   logic [pec_pkg::NP-1:0] afull_w, empty_w, hit_c;
   logic [pec_pkg::EVW-1:0] ev_c, stat_w, mask_w;
   logic req, chk_en, stat_clr, mask_we;

   pec_wr_if wif [pec_pkg::NP] ();

   // ***************************************************
   // Per-port filter and register slave
   // ***************************************************
   always_comb begin
      n = r;
      n.ms = '0;
      n.me = '0;
      n.ack = 1'b0;
      we_c = '0;
      wsop_c = '0;
      weop_c = '0;
      werr_c = '0;
      hit_c = '0;
      chk_en = r.ctrl[pec_pkg::CTRL_CHK_BIT];
      for (int p = 0; p < pec_pkg::NP; p++) begin
         hit_c[p] = in_valid_i && (in_addr_i == 8'(p));
         wsop_c[p] = in_sop_i;
         weop_c[p] = in_eop_i;
         if (!chk_en) begin
            // Bypass: words pass while room remains, no state kept
            we_c[p] = hit_c[p] && !afull_w[p];
            n.mode[p] = pec_pkg::PEC_IDLE;
            n.ovf[p] = 1'b0;
         end else if (r.ovf[p]) begin
            if (empty_w[p]) begin
               n.ovf[p] = 1'b0;
            end
            if (hit_c[p] && in_eop_i && r.mode[p] == pec_pkg::PEC_DROP) begin
               n.mode[p] = pec_pkg::PEC_IDLE;
            end
         end else if (hit_c[p]) begin
            unique case (r.mode[p])
               pec_pkg::PEC_DROP: begin
                  if (in_eop_i) begin
                     n.mode[p] = pec_pkg::PEC_IDLE;
                  end
               end
               pec_pkg::PEC_OPEN: begin
                  if (afull_w[p]) begin
                     // Reserved slot takes the truncating end
                     n.ovf[p] = 1'b1;
                     we_c[p] = 1'b1;
                     wsop_c[p] = 1'b0;
                     weop_c[p] = 1'b1;
                     werr_c[p] = 1'b1;
                     n.mode[p] = in_eop_i ? pec_pkg::PEC_IDLE : pec_pkg::PEC_DROP;
                  end else if (in_sop_i) begin
                     n.me[p] = 1'b1;
                     n.fail_addr = in_addr_i;
                     we_c[p] = 1'b1;
                     wsop_c[p] = 1'b0;
                     weop_c[p] = 1'b1;
                     werr_c[p] = 1'b1;
                     n.mode[p] = in_eop_i ? pec_pkg::PEC_IDLE : pec_pkg::PEC_DROP;
                  end else begin
                     we_c[p] = 1'b1;
                     if (in_eop_i) begin
                        n.mode[p] = pec_pkg::PEC_IDLE;
                     end
                  end
               end
               pec_pkg::PEC_IDLE: begin
                  if (afull_w[p]) begin
                     // Last write was an end, so nothing to truncate
                     n.ovf[p] = 1'b1;
                  end else if (in_sop_i) begin
                     we_c[p] = 1'b1;
                     n.mode[p] = in_eop_i ? pec_pkg::PEC_IDLE : pec_pkg::PEC_OPEN;
                  end else if (in_eop_i) begin
                     // Dropped with a missing start pulse, nothing marked errored
                     n.ms[p] = 1'b1;
                  end
               end
               default: begin
                  n.mode[p] = pec_pkg::PEC_IDLE;
               end
            endcase
         end
      end
      // Bus slave: one wait state, every address answers
      req = wb_cyc_i && wb_stb_i && !r.ack;
      stat_clr = req && !wb_we_i && (wb_adr_i == pec_pkg::REG_STAT);
      mask_we = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == pec_pkg::REG_MASK);
      if (req) begin
         n.ack = 1'b1;
         if (wb_we_i && wb_sel_i[0] && wb_adr_i == pec_pkg::REG_CTRL) begin
            n.ctrl = wb_dat_i[1:0];
         end
         unique case (wb_adr_i)
            pec_pkg::REG_CTRL: n.dat = {30'h0, r.ctrl};
            pec_pkg::REG_STAT: n.dat = 32'(stat_w);
            pec_pkg::REG_MASK: n.dat = 32'(mask_w);
            pec_pkg::REG_FLAG: n.dat = {8'h00, r.fail_addr, 8'(empty_w), 8'(r.ovf)};
            default: n.dat = 32'h0000_0000;
         endcase
      end
      ev_c = {r.me, r.ms, n.ovf & ~r.ovf};
   end

   // Flags reset with the block and move only on the clock edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
         r.ctrl <= pec_pkg::CTRL_RST;
      end else begin
         r <= n;
      end
   end

   // ***************************************************
   // Buffers and interrupt
   // ***************************************************
   for (genvar g = 0; g < pec_pkg::NP; g++) begin : g_port
      pec_pkg::pec_word_type rw;
      assign wif[g].we = we_c[g];
      assign wif[g].wword = {in_data_i, wsop_c[g], weop_c[g], werr_c[g]};
      assign afull_w[g] = wif[g].afull;
      assign empty_w[g] = wif[g].empty;

      pec_fifo u_fifo (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .wr(wif[g]),
         .rd_en_i(rd_en_i[g]),
         .eopdav_i(r.ctrl[pec_pkg::CTRL_EOPDAV_BIT]),
         .rd_valid_o(rd_valid_o[g]),
         .rd_word_o(rw),
         .data_avail_o(data_avail_o[g])
      );

      assign rd_data_o[g] = rw.data;
      assign rd_sop_o[g] = rw.sop;
      assign user_read_end_out_o[g] = rw.eop;
      assign user_read_error_out_o[g] = rw.err;

      // ************************************************
      // Checks
      // ************************************************
      sequence s_sop_in_open;
         chk_en && hit_c[g] && in_sop_i && r.mode[g] == pec_pkg::PEC_OPEN
         && !afull_w[g] && !r.ovf[g];
      endsequence
      sequence s_forced_end;
         we_c[g] && weop_c[g] && werr_c[g] && !wsop_c[g];
      endsequence

      chk_ovf_hold: assert property (@(posedge clk_i) disable iff (rst_i)
         r.ovf[g] && !empty_w[g] && chk_en |=> r.ovf[g])
         else $error("overflow flag fell before buffer emptied");
      chk_ovf_clear: assert property (@(posedge clk_i) disable iff (rst_i)
         r.ovf[g] && empty_w[g] |=> !r.ovf[g])
         else $error("overflow flag stuck after buffer emptied");
      chk_ovf_drop: assert property (@(posedge clk_i) disable iff (rst_i)
         r.ovf[g] |-> !we_c[g])
         else $error("write passed while overflow flagged");
      chk_trunc_end: assert property (@(posedge clk_i) disable iff (rst_i)
         $rose(r.ovf[g]) && $past(r.mode[g]) == pec_pkg::PEC_OPEN && $past(chk_en)
         |-> $past(we_c[g] && weop_c[g] && werr_c[g]))
         else $error("open packet not truncated on overflow");
      chk_meop_force: assert property (@(posedge clk_i) disable iff (rst_i)
         s_sop_in_open |-> s_forced_end ##1 missing_end_flag_o[g])
         else $error("start in open packet not handled");
      chk_meop_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
         missing_end_flag_o[g] |=> !missing_end_flag_o[g])
         else $error("missing end flag longer than one cycle");
      chk_fail_addr: assert property (@(posedge clk_i) disable iff (rst_i)
         missing_end_flag_o[g] |-> failing_packet_port_addr_o == 8'(g))
         else $error("failing address does not name the port");
      chk_msop_drop: assert property (@(posedge clk_i) disable iff (rst_i)
         hit_c[g] && in_eop_i && !in_sop_i && r.mode[g] == pec_pkg::PEC_IDLE && chk_en
         && !r.ovf[g] && !afull_w[g]
         |-> !we_c[g] ##1 missing_start_flag_o[g])
         else $error("orphan end marker not discarded");
      chk_under_empty: assert property (@(posedge clk_i) disable iff (rst_i)
         rd_en_i[g] && fifo_empty_status_o[g] |=> !rd_valid_o[g])
         else $error("read from empty buffer produced data");
      chk_err_end: assert property (@(posedge clk_i) disable iff (rst_i)
         rd_valid_o[g] && user_read_error_out_o[g] |-> user_read_end_out_o[g])
         else $error("errored word without end marker");
   end

   pec_irq u_irq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ev_i(ev_c),
      .clr_i(stat_clr),
      .mask_we_i(mask_we),
      .mask_i(wb_dat_i[pec_pkg::EVW-1:0]),
      .stat_o(stat_w),
      .mask_o(mask_w),
      .irq_o(irq_o)
   );

   assign wb_ack_o = r.ack;
   assign wb_dat_o = r.dat;
   assign fifo_empty_status_o = empty_w;
   assign fifo_overflow_flag_o = r.ovf;
   // Pulses follow the input word, not the buffer latency
   assign missing_start_flag_o = r.ms;
   assign missing_end_flag_o = r.me;
   assign failing_packet_port_addr_o = r.fail_addr;
endmodule

// ==== rtl/pec_pkg.sv ====
// Constants and types shared by the receive packet error checker
// Notes on behaviour
// - Overflow flag holds until buffer fully drained
// - Open packet on overflow gets errored end
// - Writes after overflow are silently dropped
// - Sink drains; stored whole packets stay intact
// - Overflow flag drops once buffer is empty
// - After overflow, accept only from fresh start
// - Truncated packet: ignore port until end marker
// - Empty status per buffer on underflow
// - Missing start/end flags pulse one cycle
// - Error pulses need not align with data
// - Orphan end markers: discard until next start
// - Start inside open packet: force errored end
// - Forced end shows error and end together
// - Missing end presents failing port address
// - Checking runs only while enabled
package pec_pkg;
   // ***************************************************
   // Sizes
   // ***************************************************
   localparam int NP = 2;
   localparam int DW = 32;
   localparam int AW = 8;
   localparam int DEPTH = 16;
   localparam int PW = 4;
   localparam int CW = 5;
   localparam int EVW = 3 * NP;
   localparam logic [CW-1:0] AFULL_LVL = 5'h0F;
   localparam logic [CW-1:0] FULL_LVL = 5'h10;
   // ***************************************************
   // Register map
   // ***************************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_MASK = 8'h08;
   localparam logic [7:0] REG_FLAG = 8'h0C;
   localparam logic [1:0] CTRL_RST = 2'h1;
   localparam int CTRL_CHK_BIT = 0;
   localparam int CTRL_EOPDAV_BIT = 1;
   localparam int EV_OVF = 0;
   localparam int EV_MSOP = NP;
   localparam int EV_MEOP = 2 * NP;
   // ***************************************************
   // Types
   // ***************************************************
   typedef enum logic [1:0] {
      PEC_IDLE = 2'b00,
      PEC_OPEN = 2'b01,
      PEC_DROP = 2'b10
   } pec_mode_type;
   typedef struct packed {
      logic [DW-1:0] data;
      logic sop;
      logic eop;
      logic err;
   } pec_word_type;
endpackage

// ==== rtl/pec_wr_if.sv ====
// Write path between the checker and one receive buffer
`timescale 1ns/1ps
interface pec_wr_if;
   logic we;
   pec_pkg::pec_word_type wword;
   logic afull;
   logic empty;
   modport filt (output we, output wword, input afull, input empty);
   modport fifo (input we, input wword, output afull, output empty);
endinterface

// ==== rtl/pec_fifo.sv ====
// Receive buffer for one port, read by the user sink
`timescale 1ns/1ps
module pec_fifo (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Write side
   pec_wr_if.fifo wr,
   // Read side
   input wire logic rd_en_i,
   input wire logic eopdav_i,
   output logic rd_valid_o,
   output pec_pkg::pec_word_type rd_word_o,
   output logic data_avail_o
);
   typedef struct packed {
      logic [pec_pkg::CW-1:0] cnt;
      logic [pec_pkg::CW-1:0] eops;
      logic [pec_pkg::PW-1:0] rp;
      logic [pec_pkg::PW-1:0] wp;
      pec_pkg::pec_word_type out;
      logic vld;
   } pec_fifo_state_type;

   pec_fifo_state_type r, n;
   pec_pkg::pec_word_type mem [pec_pkg::DEPTH];
   logic do_rd, do_wr;

   // ***************************************************
   // Next state
   // ***************************************************
   always_comb begin
      n = r;
      n.vld = 1'b0;
      do_rd = rd_en_i && (r.cnt != '0);
      do_wr = wr.we && (r.cnt != pec_pkg::FULL_LVL);
      if (do_rd) begin
         n.out = mem[r.rp];
         n.vld = 1'b1;
         n.rp = r.rp + 4'h1;
      end
      if (do_wr) begin
         n.wp = r.wp + 4'h1;
      end
      n.cnt = r.cnt + {4'h0, do_wr} - {4'h0, do_rd};
      n.eops = r.eops + {4'h0, do_wr && wr.wword.eop} - {4'h0, do_rd && mem[r.rp].eop};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // Storage carries no reset, it is only read behind the count
   always_ff @(posedge clk_i) begin
      if (do_wr) begin
         mem[r.wp] <= wr.wword;
      end
   end

   // Last slot is held back so a truncating end always fits
   assign wr.afull = (r.cnt >= pec_pkg::AFULL_LVL);
   assign wr.empty = (r.cnt == '0);
   assign rd_valid_o = r.vld;
   assign rd_word_o = r.out;
   // Holding back until a whole packet sits inside lets a drain finish
   assign data_avail_o = eopdav_i ? (r.eops != '0) : (r.cnt != '0);
endmodule

// ==== rtl/pec_irq.sv ====
// Sticky event status, mask and interrupt line
`timescale 1ns/1ps
module pec_irq (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Events and software access
   input wire logic [pec_pkg::EVW-1:0] ev_i,
   input wire logic clr_i,
   input wire logic mask_we_i,
   input wire logic [pec_pkg::EVW-1:0] mask_i,
   // State
   output logic [pec_pkg::EVW-1:0] stat_o,
   output logic [pec_pkg::EVW-1:0] mask_o,
   output logic irq_o
);
   typedef struct packed {
      logic [pec_pkg::EVW-1:0] stat;
      logic [pec_pkg::EVW-1:0] mask;
      logic irq;
   } pec_irq_state_type;

   pec_irq_state_type r, n;

   always_comb begin
      n = r;
      // A new event in the clearing cycle survives
      n.stat = (clr_i ? '0 : r.stat) | ev_i;
      if (mask_we_i) begin
         n.mask = mask_i;
      end
      n.irq = |(n.stat & n.mask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign stat_o = r.stat;
   assign mask_o = r.mask;
   assign irq_o = r.irq;
endmodule

// ==== test/pec_sink_model.sv ====
// User sink model that drains one receive buffer lane
`timescale 1ns/1ps
module pec_sink_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Pace control from the bench
   input wire logic run_i,
   input wire logic slow_i,
   // Read lane of one buffer
   input wire logic avail_i,
   input wire logic valid_i,
   input wire logic [34:0] word_i,
   output logic rd_en_o
);
   // ***************************************************
   // Reader
   // ***************************************************
   logic [34:0] got[$];
   logic tick_r;
   // Slow pace reads every other cycle, so the buffer is seen draining under stall
   always @(posedge clk_i) begin
      if (rst_i) begin
         rd_en_o <= 1'b0;
         tick_r <= 1'b0;
      end else begin
         tick_r <= ~tick_r;
         rd_en_o <= run_i & avail_i & (~slow_i | tick_r);
         if (valid_i === 1'b1) begin
            got.push_back(word_i);
         end
      end
   end
endmodule

// ==== test/test_pec_checker.sv ====
// Self-checking bench for the receive packet error checker
`timescale 1ns/1ps
module test_pec_checker;
   typedef struct packed {
      logic [7:0] a;
      logic s;
      logic e;
      logic [7:0] d;
      logic [1:0] k;
   } pec_row_type;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
   logic [7:0] wb_adr_i, in_addr_i, failing_packet_port_addr_o, fa;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q, in_data_i;
   logic in_valid_i, in_sop_i, in_eop_i;
   logic [1:0] rd_en_i, rd_valid_o, rd_sop_o, user_read_end_out_o, user_read_error_out_o;
   logic [1:0] data_avail_o, fifo_empty_status_o, fifo_overflow_flag_o;
   logic [1:0] missing_start_flag_o, missing_end_flag_o, run, slow;
   logic [1:0][31:0] rd_data_o;
   logic [34:0] eq[2][$];
   logic em[2][$];
   int fails, checks_done, ms_hi, me_hi, n;
   // Kind: 0 dropped, 1 stored as sent, 2 replaced by a forced errored end
   pec_row_type rows[12] = '{
      '{8'h00, 1'b1, 1'b0, 8'h01, 2'd1}, '{8'h00, 1'b0, 1'b0, 8'h02, 2'd1},
      '{8'h00, 1'b0, 1'b1, 8'h03, 2'd1}, '{8'h00, 1'b0, 1'b0, 8'h04, 2'd0},
      '{8'h00, 1'b0, 1'b1, 8'h05, 2'd0}, '{8'h00, 1'b1, 1'b1, 8'h06, 2'd1},
      '{8'h01, 1'b1, 1'b0, 8'h07, 2'd1}, '{8'h01, 1'b1, 1'b0, 8'h08, 2'd2},
      '{8'h01, 1'b0, 1'b0, 8'h09, 2'd0}, '{8'h01, 1'b0, 1'b1, 8'h0A, 2'd0},
      '{8'h01, 1'b1, 1'b1, 8'h0B, 2'd1}, '{8'h05, 1'b1, 1'b1, 8'h0C, 2'd0}};
   pec_checker DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .in_valid_i(in_valid_i),
      .in_addr_i(in_addr_i), .in_sop_i(in_sop_i), .in_eop_i(in_eop_i), .in_data_i(in_data_i),
      .rd_en_i(rd_en_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_sop_o(rd_sop_o),
      .user_read_end_out_o(user_read_end_out_o),
      .user_read_error_out_o(user_read_error_out_o), .data_avail_o(data_avail_o),
      .fifo_empty_status_o(fifo_empty_status_o), .fifo_overflow_flag_o(fifo_overflow_flag_o),
      .missing_start_flag_o(missing_start_flag_o), .missing_end_flag_o(missing_end_flag_o),
      .failing_packet_port_addr_o(failing_packet_port_addr_o));
   pec_sink_model s0 (.clk_i(clk_i), .rst_i(rst_i), .run_i(run[0]), .slow_i(slow[0]),
      .avail_i(data_avail_o[0]), .valid_i(rd_valid_o[0]), .rd_en_o(rd_en_i[0]),
      .word_i({rd_sop_o[0], user_read_end_out_o[0], user_read_error_out_o[0], rd_data_o[0]}));
   pec_sink_model s1 (.clk_i(clk_i), .rst_i(rst_i), .run_i(run[1]), .slow_i(slow[1]),
      .avail_i(data_avail_o[1]), .valid_i(rd_valid_o[1]), .rd_en_o(rd_en_i[1]),
      .word_i({rd_sop_o[1], user_read_end_out_o[1], user_read_error_out_o[1], rd_data_o[1]}));
   // ***************************************************
   // Clock, pulse monitor, watchdog
   // ***************************************************
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // High cycles are counted, so a stretched pulse shows as a wrong total
   always @(posedge clk_i) begin
      if (rst_i === 1'b0) begin
         ms_hi += int'(missing_start_flag_o[0]) + 16 * int'(missing_start_flag_o[1]);
         me_hi += int'(missing_end_flag_o[0]) + 16 * int'(missing_end_flag_o[1]);
         if (missing_end_flag_o !== 2'b00) fa = failing_packet_port_addr_o;
      end
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      end_of_test();
   end
   // ***************************************************
   // Tasks
   // ***************************************************
   task automatic end_of_test();
      if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic word(input logic [7:0] a, input logic s, input logic e, input logic [7:0] d);
      in_valid_i <= 1'b1;
      in_addr_i <= a;
      in_sop_i <= s;
      in_eop_i <= e;
      in_data_i <= {24'hA50000, d};
      @(posedge clk_i);
   endtask
   task automatic idle();
      in_valid_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // Forced ends are compared on their end and error markers only
   task automatic expect_w(input int p, input logic [34:0] w, input logic full);
      eq[p].push_back(full ? w : (w & 35'h300000000));
      em[p].push_back(full);
   endtask
   task automatic drain_cmp(input int p);
      logic [34:0] g[$];
      do begin
         @(posedge clk_i);
         if (p == 0) g = s0.got;
         else g = s1.got;
      end while (g.size() < eq[p].size());
      repeat (4) @(posedge clk_i);
      if (p == 0) g = s0.got;
      else g = s1.got;
      chk("read_count", eq[p].size(), g.size());
      for (int i = 0; i < eq[p].size() && i < g.size(); i++) begin
         chk("read_word", eq[p][i], em[p][i] ? g[i] : (g[i] & 35'h300000000));
      end
      eq[p].delete();
      em[p].delete();
      if (p == 0) s0.got.delete();
      else s1.got.delete();
   endtask
   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, in_valid_i, in_sop_i, in_eop_i} = 6'h00;
      {wb_adr_i, in_addr_i, wb_dat_i, in_data_i} = 80'h0;
      wb_sel_i = 4'hF;
      {run, slow, fails, checks_done, ms_hi, me_hi, fa} = 0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("empty_reset", 2'b11, fifo_empty_status_o);
      wb(1'b0, pec_pkg::REG_CTRL, 32'h0);
      chk("ctrl_reset", 32'h1, q);
      wb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, q);
      wb(1'b1, pec_pkg::REG_CTRL, 32'h3);
      run <= 2'b11;
      foreach (rows[i]) begin
         word(rows[i].a, rows[i].s, rows[i].e, rows[i].d);
         if (rows[i].k != 2'd0) expect_w(int'(rows[i].a), (rows[i].k == 2'd1) ?
            {rows[i].s, rows[i].e, 1'b0, 24'hA50000, rows[i].d} : {3'b011, 32'h0},
            rows[i].k == 2'd1);
      end
      idle();
      drain_cmp(0);
      drain_cmp(1);
      chk("msop_pulses", 1, ms_hi);
      chk("meop_pulses", 16, me_hi);
      chk("fail_addr", 8'h01, fa);
      wb(1'b0, pec_pkg::REG_STAT, 32'h0);
      chk("status", 32'h24, q);
      chk("irq_masked", 1'b0, irq_o);
      // Overflow with sink 0 stalled: whole packet, then an open one that fills
      run <= 2'b10;
      word(8'h00, 1'b1, 1'b1, 8'h20);
      expect_w(0, {3'b110, 32'hA5000020}, 1'b1);
      word(8'h00, 1'b1, 1'b0, 8'h21);
      expect_w(0, {3'b100, 32'hA5000021}, 1'b1);
      for (int i = 0; i < 13; i++) begin
         word(8'h00, 1'b0, 1'b0, 8'h30 + 8'(i));
         expect_w(0, {3'b000, 32'hA5000030 + 32'(i)}, 1'b1);
      end
      word(8'h00, 1'b0, 1'b0, 8'h99);
      expect_w(0, {3'b011, 32'h0}, 1'b0);
      word(8'h00, 1'b0, 1'b1, 8'h9A);
      word(8'h00, 1'b1, 1'b1, 8'h9B);
      idle();
      chk("ovf_set", 2'b01, fifo_overflow_flag_o);
      wb(1'b0, pec_pkg::REG_FLAG, 32'h0);
      chk("flags_reg", 32'h00010201, q);
      wb(1'b1, pec_pkg::REG_MASK, 32'h1);
      repeat (3) @(posedge clk_i);
      chk("irq_up", 1'b1, irq_o);
      wb(1'b0, pec_pkg::REG_STAT, 32'h0);
      chk("status_ovf", 32'h01, q);
      repeat (3) @(posedge clk_i);
      chk("irq_clear", 1'b0, irq_o);
      chk("ovf_hold", 2'b01, fifo_overflow_flag_o);
      run <= 2'b11;
      slow <= 2'b01;
      n = 0;
      while (fifo_empty_status_o[0] !== 1'b1 && n < 500) begin
         @(posedge clk_i);
         n++;
      end
      repeat (2) @(posedge clk_i);
      chk("ovf_drop", 2'b00, fifo_overflow_flag_o);
      word(8'h00, 1'b0, 1'b1, 8'hA0);
      word(8'h00, 1'b0, 1'b0, 8'hA1);
      word(8'h00, 1'b1, 1'b1, 8'hA2);
      expect_w(0, {3'b110, 32'hA50000A2}, 1'b1);
      idle();
      drain_cmp(0);
      // Bypass keeps an orphan word, both availability modes, then reset in mid-run
      run <= 2'b10;
      wb(1'b1, pec_pkg::REG_CTRL, 32'h0);
      word(8'h00, 1'b0, 1'b0, 8'hB0);
      idle();
      chk("stored", 1'b0, fifo_empty_status_o[0]);
      chk("bypass_flags", 2, ms_hi);
      chk("avail_level", 1'b1, data_avail_o[0]);
      wb(1'b1, pec_pkg::REG_CTRL, 32'h3);
      chk("avail_whole", 1'b0, data_avail_o[0]);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk("reset_state", 7'h60, {fifo_empty_status_o, fifo_overflow_flag_o, irq_o,
         rd_valid_o});
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, pec_pkg::REG_CTRL, 32'h0);
      chk("ctrl_after_reset", 32'h1, q);
      end_of_test();
   end
endmodule
